// ===== common/ccr_pkg.sv
// constants, register map and state codes for the chip control register bank
//
// Contract
// R01 - The overrun watermark register holds a 12-bit read/write threshold in bits 11-0, bits 15-12 are reserved.
// R02 - The threshold counts 32-bit double words and resets to 0x0040, which is 256 bytes of free space.
// R03 - The identification register reads family code 15-8, chip code 7-4, revision 3-1, with bit 0 a read/write bit resetting to zero.
// R04 - Global control bit 9 picks the LED mode: 0 gives link/activity and 100BT speed, 1 gives link and activity.
// R05 - Every write to the indirect control register starts an indirect operation, whose kind follows bit 12; the code drops writes while a read runs.
// R06 - With bit 12 set the selected counter is read and then cleared, with bit 12 clear nothing happens.
// R07 - Table select bits 11-10 equal to 11 pick the statistics counters, and the host never uses 00, 01 or 10.
// R08 - Bits 4-0 of the indirect control register pick one of 32 counters.
// R09 - The low data register shows bits 15-0 of the indirect result and resets to 0x0000.
// R10 - The high data register shows bits 31-16 of the indirect result and resets to zero.
// R11 - With power event bit 14 set the wake output waits until all clocks are ready, otherwise it asserts at once.
// R12 - The wake output delay applies only while the auto wake-up enable bit 7 is set.
// R13 - With bit 7 set the device leaves low power once signal energy has lasted beyond the wake-up time.
// R14 - Both data registers hold the counter value before the host can read them, and the host reads them only after the command.
// R15 - The host writes back reset values into reserved fields of the global control register.
package ccr_pkg;
    // --------------------------------------------------------------
    // register byte offsets
    // --------------------------------------------------------------
    localparam logic [7:0]  OFS_OVERRUN   = 8'hb4;
    localparam logic [7:0]  OFS_CHIP_ID   = 8'hc0;
    localparam logic [7:0]  OFS_GLOBAL    = 8'hc6;
    localparam logic [7:0]  OFS_IND_CTRL  = 8'hc8;
    localparam logic [7:0]  OFS_IND_LOW   = 8'hd0;
    localparam logic [7:0]  OFS_IND_HIGH  = 8'hd2;
    localparam logic [7:0]  OFS_PWR_EVENT = 8'hd4;
    // --------------------------------------------------------------
    // reset values and field positions
    // --------------------------------------------------------------
    localparam logic [11:0] RST_THRESHOLD = 12'h040;
    localparam logic [15:0] RST_GLOBAL    = 16'h0835;
    localparam logic [15:0] RST_ZERO      = 16'h0000;
    localparam int          THR_MSB       = 11;
    localparam int          LED_SEL_BIT   = 9;
    localparam int          RD_EN_BIT     = 12;
    localparam int          TBL_MSB       = 11;
    localparam int          TBL_LSB       = 10;
    localparam logic [1:0]  TBL_COUNTERS  = 2'h3;
    localparam int          ADDR_MSB      = 4;
    localparam int          DELAY_EN_BIT  = 14;
    localparam int          PWR_RSV_BIT   = 13;
    localparam int          AUTO_WAKE_BIT = 7;
    // --------------------------------------------------------------
    // indirect sequencer states
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        CCR_IDLE    = 2'b00,
        CCR_CAPTURE = 2'b01,
        CCR_CLEAR   = 2'b10
    } ccr_state_t;
endpackage

// ===== hw/ccr_regs.sv
// chip control, identification, led, counter access and wake event registers
`timescale 1ns/1ns
`default_nettype none
module ccr_regs
    import ccr_pkg::*;
#(
    parameter logic [7:0] FAMILY_CODE = 8'h5a,  // arbitrary value
    parameter logic [3:0] CHIP_CODE   = 4'h3,   // arbitrary value
    parameter logic [2:0] REV_CODE    = 3'h2    // arbitrary value
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [1:0]  reg_be,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             ind_busy,
    output logic      [4:0]  cnt_addr,
    input  wire logic [31:0] cnt_value,
    output logic             cnt_clear,
    output logic      [11:0] threshold_field,
    input  wire logic        link_up,
    input  wire logic        activity,
    input  wire logic        speed_100,
    output logic             led0,
    output logic             led1,
    input  wire logic        wake_event,
    input  wire logic        clocks_ready,
    output logic             wake_event_output,
    input  wire logic        low_power_state,
    input  wire logic        energy_time_met,
    output logic             wake_to_normal
);
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // byte-lane merge of a write into a stored word
    function automatic logic [15:0] ccr_merge(input logic [15:0] old_v,
                                              input logic [15:0] new_v,
                                              input logic [1:0]  be);
        logic [15:0] res;
        res = old_v;
        if (be[0]) begin
            res[7:0] = new_v[7:0];
        end
        if (be[1]) begin
            res[15:8] = new_v[15:8];
        end
        return res;
    endfunction

    // --------------------------------------------------------------
    // storage
    // --------------------------------------------------------------
    logic       [11:0] overrun_thr;
    logic              id_spare;
    logic       [15:0] global_chip_control;
    logic       [15:0] indirect_access_control;
    logic       [15:0] indirect_data_low;
    logic       [15:0] indirect_data_high;
    logic              pwr_delay_en;
    logic              pwr_spare;
    logic              pwr_auto_wake;
    ccr_state_t        state;
    ccr_state_t        next_state;

    // --------------------------------------------------------------
    // address decode
    // --------------------------------------------------------------
    // write strobes per register
    wire        wr_go     = ce && reg_wr;
    wire        wr_thr    = wr_go && (reg_addr == OFS_OVERRUN);
    wire        wr_id     = wr_go && (reg_addr == OFS_CHIP_ID);
    wire        wr_glob   = wr_go && (reg_addr == OFS_GLOBAL);
    wire        wr_ictl   = wr_go && (reg_addr == OFS_IND_CTRL);
    wire        wr_ilow   = wr_go && (reg_addr == OFS_IND_LOW);
    wire        wr_ihigh  = wr_go && (reg_addr == OFS_IND_HIGH);
    wire        wr_pwr    = wr_go && (reg_addr == OFS_PWR_EVENT);
    // merged write values
    wire [15:0] thr_new   = ccr_merge({4'h0, overrun_thr}, reg_wdata, reg_be);
    wire [15:0] id_new    = ccr_merge({15'h0000, id_spare}, reg_wdata, reg_be);
    wire [15:0] pwr_old   = {1'b0, pwr_delay_en, pwr_spare, 5'h00,
                             pwr_auto_wake, 7'h00};
    wire [15:0] pwr_new   = ccr_merge(pwr_old, reg_wdata, reg_be);
    wire [15:0] ictl_new  = ccr_merge(indirect_access_control, reg_wdata, reg_be);

    // --------------------------------------------------------------
    // read mux
    // --------------------------------------------------------------
    // unmapped offsets read as zero
    wire [15:0] id_word   = {FAMILY_CODE, CHIP_CODE, REV_CODE, id_spare};  // R03
    wire [15:0] rd_mux    =
        (reg_addr == OFS_OVERRUN)   ? {4'h0, overrun_thr} :
        (reg_addr == OFS_CHIP_ID)   ? id_word :
        (reg_addr == OFS_GLOBAL)    ? global_chip_control :
        (reg_addr == OFS_IND_CTRL)  ? indirect_access_control :
        (reg_addr == OFS_IND_LOW)   ? indirect_data_low :
        (reg_addr == OFS_IND_HIGH)  ? indirect_data_high :
        (reg_addr == OFS_PWR_EVENT) ? pwr_old : RST_ZERO;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= RST_ZERO;
        end else if (ce && reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

    // --------------------------------------------------------------
    // plain control registers
    // --------------------------------------------------------------
    // threshold, id spare bit, global control, wake control
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            overrun_thr         <= RST_THRESHOLD;                 // R02
            id_spare            <= 1'b0;                          // R03
            global_chip_control <= RST_GLOBAL;
            pwr_delay_en        <= 1'b0;
            pwr_spare           <= 1'b0;
            pwr_auto_wake       <= 1'b0;
        end else begin
            if (wr_thr) begin
                overrun_thr <= thr_new[THR_MSB:0];                // R01
            end
            if (wr_id) begin
                id_spare <= id_new[0];                            // R03
            end
            if (wr_glob) begin
                global_chip_control <= ccr_merge(global_chip_control, reg_wdata, reg_be);
            end
            if (wr_pwr) begin
                pwr_delay_en  <= pwr_new[DELAY_EN_BIT];
                pwr_spare     <= pwr_new[PWR_RSV_BIT];
                pwr_auto_wake <= pwr_new[AUTO_WAKE_BIT];
            end
        end
    end

    assign threshold_field = overrun_thr;  // R01

    // --------------------------------------------------------------
    // indirect counter access
    // --------------------------------------------------------------
    // a counter read needs read enable and the counter table
    wire rd_cmd = wr_ictl && ictl_new[RD_EN_BIT]                       // R05 R06
                  && (ictl_new[TBL_MSB:TBL_LSB] == TBL_COUNTERS);      // R07

    always_comb begin
        next_state = state;
        case (state)
            CCR_IDLE: begin
                if (rd_cmd) begin
                    next_state = CCR_CAPTURE;                         // R06
                end
            end
            CCR_CAPTURE: next_state = CCR_CLEAR;
            CCR_CLEAR:   next_state = CCR_IDLE;
            default:     next_state = CCR_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state                   <= CCR_IDLE;
            indirect_access_control <= RST_ZERO;
        end else if (ce) begin
            state <= next_state;
            if (wr_ictl && (state == CCR_IDLE)) begin
                indirect_access_control <= ictl_new;                  // R05
            end
        end
    end

    // counter select follows the stored address field
    assign cnt_addr  = indirect_access_control[ADDR_MSB:0];          // R08
    assign cnt_clear = ce && (state == CCR_CLEAR);                   // R06
    assign ind_busy  = (state != CCR_IDLE);                          // R14

    // data words: loaded from the counter, or written by the host
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            indirect_data_low  <= RST_ZERO;                           // R09
            indirect_data_high <= RST_ZERO;                           // R10
        end else if (ce) begin
            if (state == CCR_CAPTURE) begin
                indirect_data_low  <= cnt_value[15:0];                // R09 R14
                indirect_data_high <= cnt_value[31:16];               // R10 R14
            end else begin
                if (wr_ilow) begin
                    indirect_data_low <= ccr_merge(indirect_data_low, reg_wdata, reg_be);
                end
                if (wr_ihigh) begin
                    indirect_data_high <= ccr_merge(indirect_data_high, reg_wdata, reg_be);
                end
            end
        end
    end

    // --------------------------------------------------------------
    // led mode and wake logic
    // --------------------------------------------------------------
    wire led_sel    = global_chip_control[LED_SEL_BIT];
    wire next_led0  = led_sel ? link_up : (link_up && !activity);    // R04
    wire next_led1  = led_sel ? activity : speed_100;                // R04
    // delay only counts while auto wake-up is on
    wire hold_wake  = pwr_auto_wake && pwr_delay_en && !clocks_ready; // R11 R12
    wire next_wake  = wake_event && !hold_wake;                      // R11
    wire next_norm  = pwr_auto_wake && low_power_state && energy_time_met; // R13

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            led0              <= 1'b0;
            led1              <= 1'b0;
            wake_event_output <= 1'b0;
            wake_to_normal    <= 1'b0;
        end else if (ce) begin
            led0              <= next_led0;
            led1              <= next_led1;
            wake_event_output <= next_wake;
            wake_to_normal    <= next_norm;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking ccr_cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    a_thr_upper_zero: assert property (  // R01
        ce && reg_rd && reg_addr == OFS_OVERRUN |=> reg_rdata[15:12] == 4'h0)
        else $error("overrun threshold upper bits not zero");

    a_thr_write_lands: assert property (  // R01
        wr_thr && reg_be == 2'b11 |=> threshold_field == $past(reg_wdata[11:0]))
        else $error("overrun threshold write lost");

    a_id_read_codes: assert property (  // R03
        ce && reg_rd && reg_addr == OFS_CHIP_ID
        |=> reg_rdata[15:1] == {FAMILY_CODE, CHIP_CODE, REV_CODE})
        else $error("identification fields wrong");

    a_led_mode_one: assert property (  // R04
        ce && led_sel |=> led1 == $past(activity) && led0 == $past(link_up))
        else $error("led mode one mapping wrong");

    a_cmd_starts_read: assert property (  // R06
        state == CCR_IDLE && rd_cmd |=> state == CCR_CAPTURE ##1 cnt_clear [*1])
        else $error("counter read did not run to clear");

    a_no_read_off: assert property (  // R06
        state == CCR_IDLE && wr_ictl && !reg_wdata[RD_EN_BIT] && reg_be[1]
        |=> state == CCR_IDLE)
        else $error("read started with enable low");

    a_table_gate: assert property (  // R07
        state == CCR_IDLE && wr_ictl && reg_be[1]
        && reg_wdata[TBL_MSB:TBL_LSB] != TBL_COUNTERS |=> !ind_busy)
        else $error("reserved table started a read");

    a_capture_words: assert property (  // R09
        ce && state == CCR_CAPTURE
        |=> {indirect_data_high, indirect_data_low} == $past(cnt_value))
        else $error("counter value not captured");

    a_clear_after_load: assert property (  // R14
        cnt_clear |-> $past(state) == CCR_CAPTURE && !ind_busy == 1'b0)
        else $error("clear without prior capture");

    a_wake_held: assert property (  // R11
        ce && pwr_auto_wake && pwr_delay_en && !clocks_ready |=> !wake_event_output)
        else $error("wake output not held for clocks");

    a_wake_no_delay: assert property (  // R12
        ce && !pwr_auto_wake && wake_event |=> wake_event_output)
        else $error("wake output delayed without auto wake");

    a_auto_wake: assert property (  // R13
        ce && pwr_auto_wake && low_power_state && energy_time_met |=> wake_to_normal)
        else $error("auto wake did not fire");
endmodule
`default_nettype wire

// ===== bench/ccr_regs_bench.sv
// self-checking bench for the chip control register bank
`timescale 1ns/1ns
`default_nettype none
module ccr_regs_bench;
    import ccr_pkg::*;
    // ----------------------------------------------------------------
    // signals, model state and counters
    // ----------------------------------------------------------------
    localparam logic [7:0]  FAM = 8'h3c;    // arbitrary value
    localparam logic [3:0]  CHP = 4'h9;     // arbitrary value
    localparam logic [2:0]  REV = 3'h5;     // arbitrary value
    localparam logic [15:0] ID  = {FAM, CHP, REV, 1'b0};
    logic        ref_clk, reset, ce, reg_wr, reg_rd, ind_busy, cnt_clear;
    logic [7:0]  reg_addr;
    logic [1:0]  reg_be;
    logic [15:0] reg_wdata, reg_rdata, rnd;
    logic [4:0]  cnt_addr;
    logic [31:0] cnt_value;
    logic [11:0] threshold_field, thr;
    logic        link_up, activity, speed_100, led0, led1, wake_event, clocks_ready;
    logic        wake_event_output, low_power_state, energy_time_met, wake_to_normal;
    logic [31:0] cnt_mem [32];
    int          seed, fails, samples_checked, clears, i, a;
    int          addrs[$];
    ccr_regs #(.FAMILY_CODE(FAM), .CHIP_CODE(CHP), .REV_CODE(REV)) ccr_regs_i (
        .ref_clk(ref_clk), .reset(reset), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ind_busy(ind_busy), .cnt_addr(cnt_addr), .cnt_value(cnt_value),
        .cnt_clear(cnt_clear), .threshold_field(threshold_field), .link_up(link_up),
        .activity(activity), .speed_100(speed_100), .led0(led0), .led1(led1),
        .wake_event(wake_event), .clocks_ready(clocks_ready),
        .wake_event_output(wake_event_output), .low_power_state(low_power_state),
        .energy_time_met(energy_time_met), .wake_to_normal(wake_to_normal));
    // ----------------------------------------------------------------
    // clock, counter model and helpers
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // counters answer combinationally and clear on the pulse
    assign cnt_value = cnt_mem[cnt_addr];
    always @(posedge ref_clk) begin
        if (cnt_clear === 1'b1) begin
            cnt_mem[cnt_addr] <= 32'h0000_0000;
            clears++;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // a free edge before each request keeps a strobe from toggling in one step
    task automatic wr(input logic [7:0] ad, input logic [15:0] d, input logic [1:0] be);
        @(posedge ref_clk);
        #1 reg_wr = 1'b1;
        reg_addr = ad;
        reg_wdata = d;
        reg_be = be;
        @(posedge ref_clk);
        #1 reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [15:0] exp, input logic [15:0] m);
        @(posedge ref_clk);
        #1 reg_rd = 1'b1;
        reg_addr = ad;
        @(posedge ref_clk);
        #1 reg_rd = 1'b0;
        chk(reg_rdata & m, exp & m);
    endtask
    // one full counter read: command, capture, clear, both halves
    task automatic cnt_read(input int n);
        logic [31:0] exp;
        exp = cnt_mem[n];
        wr(OFS_IND_CTRL, 16'h1c00 | n[15:0], 2'b11);
        chk(ind_busy, 1);
        chk(cnt_addr, n[4:0]);
        @(posedge ref_clk);
        #1 chk(cnt_clear, 1);
        @(posedge ref_clk);
        #1 chk(ind_busy, 0);
        chk(cnt_clear, 0);
        rd(OFS_IND_LOW, exp[15:0], 16'hffff);
        rd(OFS_IND_HIGH, exp[31:16], 16'hffff);
        chk(cnt_mem[n], 0);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // watchdog
    // ----------------------------------------------------------------
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 11691;
        {reg_wr, reg_rd, reg_addr, reg_be, reg_wdata} = '0;
        {link_up, activity, speed_100, wake_event, clocks_ready} = '0;
        {low_power_state, energy_time_met} = '0;
        fails = 0;
        samples_checked = 0;
        clears = 0;
        for (i = 0; i < 32; i++) cnt_mem[i] = $random(seed);
        reset = 1'b1;
        ce = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1 reset = 1'b0;
        // reset values and an unmapped offset
        chk(threshold_field, 12'h040);
        rd(OFS_OVERRUN, 16'h0040, 16'h0fff);
        rd(OFS_CHIP_ID, ID, 16'hffff);
        rd(OFS_GLOBAL, RST_GLOBAL, 16'hffff);
        rd(OFS_IND_CTRL, 16'h0000, 16'hfc1f);
        rd(OFS_IND_LOW, 16'h0000, 16'hffff);
        rd(OFS_IND_HIGH, 16'h0000, 16'hffff);
        rd(OFS_PWR_EVENT, 16'h0000, 16'h4080);
        rd(8'hb6, 16'h0000, 16'hffff);
        // threshold: low byte only, then a random full word
        wr(OFS_OVERRUN, 16'hff2d, 2'b01);
        thr = 12'h02d;
        chk(threshold_field, thr);
        rnd = 16'($random(seed));
        thr = rnd[11:0];
        wr(OFS_OVERRUN, rnd, 2'b11);
        chk(threshold_field, thr);
        rd(OFS_OVERRUN, {4'h0, thr}, 16'h0fff);
        // identification: only bit 0 takes a write
        wr(OFS_CHIP_ID, 16'hffff, 2'b11);
        rd(OFS_CHIP_ID, ID | 16'h0001, 16'hffff);
        wr(OFS_CHIP_ID, 16'h0000, 2'b11);
        rd(OFS_CHIP_ID, ID, 16'hffff);
        // led modes over every input combination
        for (i = 0; i < 16; i++) begin
            wr(OFS_GLOBAL, RST_GLOBAL | (16'(i[3]) << LED_SEL_BIT), 2'b11);
            {link_up, activity, speed_100} = i[2:0];
            @(posedge ref_clk);
            #1;
            if (i[3]) begin
                chk(led0, i[2]);
                chk(led1, i[1]);
            end else begin
                chk(led0, i[2] & ~i[1]);
                chk(led1, i[0]);
            end
        end
        // counter reads at both ends, then random, then re-read after clear
        addrs = {0, 31, 5};
        repeat (5) addrs.push_back($unsigned($random(seed)) % 32);
        addrs.push_back(31);
        foreach (addrs[k]) cnt_read(addrs[k]);
        // commands that must not touch the counters
        a = clears;
        for (i = 0; i < 8; i++) begin
            if (i != 7) begin
                wr(OFS_IND_CTRL, (16'(i[2]) << RD_EN_BIT) | (16'(i[1:0]) << 10) | 16'h0003,
                   2'b11);
                chk(ind_busy, 0);
                repeat (2) @(posedge ref_clk);
                #1 chk(clears, a);
            end
        end
        // wake output delay and auto wake-up over every combination
        for (i = 0; i < 64; i++) begin
            wr(OFS_PWR_EVENT, (16'(i[5]) << DELAY_EN_BIT) | (16'(i[4]) << AUTO_WAKE_BIT)
               | 16'h8000, 2'b11);
            {wake_event, clocks_ready, low_power_state, energy_time_met} = i[3:0];
            @(posedge ref_clk);
            #1 chk(wake_event_output, i[3] & (~(i[5] & i[4]) | i[2]));
            chk(wake_to_normal, i[4] & i[1] & i[0]);
        end
        // clock enable low freezes every register
        ce = 1'b0;
        wake_event = 1'b0;
        wr(OFS_OVERRUN, {4'h0, ~thr}, 2'b11);
        wr(OFS_IND_CTRL, 16'h1c00, 2'b11);
        chk(ind_busy, 0);
        chk(threshold_field, thr);
        chk(wake_event_output, 1);
        ce = 1'b1;
        rd(OFS_PWR_EVENT, 16'h4080, 16'hc080);
        give_verdict();
    end
endmodule
`default_nettype wire
